// File: shared/bst_pkg.sv
// Constants shared by the backlight standby timer, its panel model and its bench
package bst_pkg;
  // Parameter address map and widths
  localparam int unsigned         ADDR_W           = 12;
  localparam int unsigned         DATA_W           = 16;
  localparam logic [ADDR_W-1:0]   OP_BRIGHT_ADDR   = 12'h024;
  localparam logic [ADDR_W-1:0]   SB_TIMEOUT_ADDR  = 12'h2ea;
  localparam logic [ADDR_W-1:0]   SB_BRIGHT_ADDR   = 12'h2eb;

  // Brightness steps
  localparam int unsigned         LEVEL_W          = 4;
  localparam logic [LEVEL_W-1:0]  LEVEL_MIN        = 4'h0;
  localparam logic [LEVEL_W-1:0]  LEVEL_MAX        = 4'h9;
  localparam logic [LEVEL_W-1:0]  OP_BRIGHT_RST    = 4'h6;
  localparam logic [LEVEL_W-1:0]  SB_BRIGHT_RST    = 4'h0;

  // Inactivity period in seconds
  localparam int unsigned         SEC_W            = 14;
  localparam logic [SEC_W-1:0]    TIMEOUT_MIN      = 14'h003c;
  localparam logic [SEC_W-1:0]    TIMEOUT_MAX      = 14'h270f;
  localparam logic [SEC_W-1:0]    TIMEOUT_RST      = 14'h0384;

  // One-second tick from the 100 MHz clock
  localparam int unsigned         CLK_PERIOD_NS    = 10;
  localparam int unsigned         NS_PER_S         = 1000000000;
  localparam int unsigned         TICK_PERIOD_S    = 1;
  localparam int unsigned         TICK_CYCLES      = TICK_PERIOD_S * (NS_PER_S / CLK_PERIOD_NS);

  // Front-panel buttons
  localparam int unsigned         BUTTONS          = 3;

  typedef enum logic {BST_OPERATE, BST_STANDBY} bst_mode_t;
endpackage

// File: verilog/bst_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bst_pin_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // A change counts only once the two later stages agree
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule // bst_pin_sync

// File: verilog/bst_backlight_timer.sv
// Backlight level control with inactivity standby timer
`timescale 1ns/10ps
module bst_backlight_timer #(
  parameter int unsigned TICK_CYCLES = bst_pkg::TICK_CYCLES
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [bst_pkg::BUTTONS-1:0]  btn,
  input  wire logic                         par_wr,
  input  wire logic                         par_rd,
  input  wire logic [bst_pkg::ADDR_W-1:0]   par_addr,
  input  wire logic [bst_pkg::DATA_W-1:0]   par_wdata,
  output logic      [bst_pkg::DATA_W-1:0]   par_rdata,
  output logic                              par_rd_valid,
  output logic                              par_err,
  output logic      [bst_pkg::LEVEL_W-1:0]  backlight_level,
  output logic                              bl_standby
);
  import bst_pkg::*;

  localparam int unsigned TW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [BUTTONS-1:0] btn_lvl;
  logic [BUTTONS-1:0] btn_q;
  logic               press;

  logic [TW-1:0]      tick_cnt;
  logic               tick;
  logic [SEC_W-1:0]   idle_sec;
  bst_mode_t          mode;
  logic [LEVEL_W-1:0] op_bright;
  logic [LEVEL_W-1:0] sb_bright;
  logic [SEC_W-1:0]   timeout;

  logic [TW-1:0]      next_tick_cnt;
  logic               next_tick;
  logic [SEC_W-1:0]   next_idle_sec;
  bst_mode_t          next_mode;
  logic [LEVEL_W-1:0] next_op_bright;
  logic [LEVEL_W-1:0] next_sb_bright;
  logic [SEC_W-1:0]   next_timeout;
  logic [LEVEL_W-1:0] next_level;
  logic [DATA_W-1:0]  next_rdata;
  logic               next_rd_valid;
  logic               next_err;
  logic               bright_ok;
  logic               timeout_ok;
  logic               expire;

  for (genvar i = 0; i < BUTTONS; i++) begin : g_btn
    bst_pin_sync u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (btn[i]),
      .level   (btn_lvl[i])
    );
  end

  // Only a fresh push counts, so a held button does not pin the timer
  assign press = |(btn_lvl & ~btn_q);

  always_comb begin
    next_tick_cnt  = tick_cnt + TW'(1);
    next_tick      = 1'b0;
    next_idle_sec  = idle_sec;
    next_mode      = mode;
    next_op_bright = op_bright;
    next_sb_bright = sb_bright;
    next_timeout   = timeout;
    next_rdata     = par_rdata;
    next_rd_valid  = 1'b0;
    next_err       = 1'b0;
    bright_ok      = par_wdata <= DATA_W'(LEVEL_MAX);
    timeout_ok     = (par_wdata >= DATA_W'(TIMEOUT_MIN)) && (par_wdata <= DATA_W'(TIMEOUT_MAX));
    expire         = tick && ((idle_sec + SEC_W'(1)) >= timeout);

    // Free-running one-second tick
    if (tick_cnt == TICK_LAST) begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end

    // Out-of-range writes are refused and leave the setting unchanged
    if (par_wr) begin
      case (par_addr)
        OP_BRIGHT_ADDR: begin
          if (bright_ok) next_op_bright = par_wdata[LEVEL_W-1:0];
          else next_err = 1'b1;
        end
        SB_BRIGHT_ADDR: begin
          if (bright_ok) next_sb_bright = par_wdata[LEVEL_W-1:0];
          else next_err = 1'b1;
        end
        SB_TIMEOUT_ADDR: begin
          if (timeout_ok) next_timeout = par_wdata[SEC_W-1:0];
          else next_err = 1'b1;
        end
        default: next_err = 1'b1;
      endcase
    end else if (par_rd) begin
      next_rd_valid = 1'b1;
      case (par_addr)
        OP_BRIGHT_ADDR:  next_rdata = DATA_W'(op_bright);
        SB_BRIGHT_ADDR:  next_rdata = DATA_W'(sb_bright);
        SB_TIMEOUT_ADDR: next_rdata = DATA_W'(timeout);
        default: begin
          next_rdata = '0;
          next_err   = 1'b1;
        end
      endcase
    end

    case (mode)
      BST_OPERATE: begin
        // A push in the same cycle as expiry wins, so the panel never blinks to standby
        if (press) begin
          next_idle_sec = '0;
        end else if (expire) begin
          next_mode = BST_STANDBY;
        end else if (tick) begin
          next_idle_sec = idle_sec + SEC_W'(1);
        end
      end
      BST_STANDBY: begin
        // Count stops in standby; only a push leaves it
        if (press) begin
          next_mode     = BST_OPERATE;
          next_idle_sec = '0;
        end
      end
      default: next_mode = BST_OPERATE;
    endcase

    // Level follows the next settings so the output never lags a write
    next_level = (next_mode == BST_STANDBY) ? next_sb_bright : next_op_bright;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      btn_q           <= '0;
      tick_cnt        <= '0;
      tick            <= 1'b0;
      idle_sec        <= '0;
      mode            <= BST_OPERATE;
      op_bright       <= OP_BRIGHT_RST;
      sb_bright       <= SB_BRIGHT_RST;
      timeout         <= TIMEOUT_RST;
      backlight_level <= OP_BRIGHT_RST;
      bl_standby      <= 1'b0;
      par_rdata       <= '0;
      par_rd_valid    <= 1'b0;
      par_err         <= 1'b0;
    end else begin
      btn_q           <= btn_lvl;
      tick_cnt        <= next_tick_cnt;
      tick            <= next_tick;
      idle_sec        <= next_idle_sec;
      mode            <= next_mode;
      op_bright       <= next_op_bright;
      sb_bright       <= next_sb_bright;
      timeout         <= next_timeout;
      backlight_level <= next_level;
      bl_standby      <= (next_mode == BST_STANDBY);
      par_rdata       <= next_rdata;
      par_rd_valid    <= next_rd_valid;
      par_err         <= next_err;
    end
  end

  // All checks share the one clock; all but restart_operate_a pause while reset is held
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  level_range_a: assert property (backlight_level <= LEVEL_MAX && op_bright <= LEVEL_MAX)
    else $error("backlight level above top step");
  restart_operate_a: assert property (disable iff (1'b0) rst |=> (!bl_standby && idle_sec == '0))
    else $error("restart did not select operation level");
  standby_entry_a: assert property (mode == BST_OPERATE && expire && !press |=> bl_standby)
    else $error("expired period did not enter standby");
  press_restart_a: assert property (press && !par_wr |=> !bl_standby && idle_sec == '0
                                    && backlight_level == op_bright)
    else $error("button push did not restore operation level");
  timeout_range_a: assert property (timeout >= TIMEOUT_MIN && timeout <= TIMEOUT_MAX)
    else $error("timeout outside 60 to 9999");
  op_write_a: assert property (par_wr && par_addr == OP_BRIGHT_ADDR && bright_ok
                               |=> DATA_W'(op_bright) == $past(par_wdata))
    else $error("operation brightness write lost");
  sb_write_a: assert property (par_wr && par_addr == SB_BRIGHT_ADDR && !bright_ok
                               |=> $stable(sb_bright) ##0 par_err)
    else $error("bad standby brightness write accepted");
  level_select_a: assert property (backlight_level == (bl_standby ? sb_bright : op_bright))
    else $error("output level does not follow mode");
  tick_space_a: assert property (tick |=> !tick)
    else $error("tick wider than one cycle");
  timeout_write_a: assert property (par_wr && par_addr == SB_TIMEOUT_ADDR && !timeout_ok
                                    |=> $stable(timeout) && par_err)
    else $error("bad timeout write accepted");
  timeout_read_a: assert property (par_rd && !par_wr && par_addr == SB_TIMEOUT_ADDR
                                   |=> par_rd_valid && par_rdata == DATA_W'($past(timeout)))
    else $error("timeout read returned wrong value");
  standby_hold_a: assert property (bl_standby && !press |=> bl_standby)
    else $error("standby left without a button push");
  idle_count_a: assert property (mode == BST_OPERATE && tick && !press && !expire
                                 |=> idle_sec == $past(idle_sec) + SEC_W'(1))
    else $error("idle seconds did not advance on tick");

  // Main scenarios
  cov_standby_c: cover property (!bl_standby ##1 bl_standby);
  cov_push_op_c: cover property (!bl_standby && press);
  cov_wake_c:    cover property (bl_standby ##1 press ##1 !bl_standby);
  cov_bad_wr_c:  cover property (par_wr && par_addr == SB_TIMEOUT_ADDR && !timeout_ok);
endmodule // bst_backlight_timer

// File: tb/bst_panel_model.sv
// Front-panel buttons and backlight driver stand-in
`timescale 1ns/10ps
module bst_panel_model (
  input  wire logic                         ref_clk,
  input  wire logic [bst_pkg::LEVEL_W-1:0]  level,
  output logic      [bst_pkg::BUTTONS-1:0]  btn
);
  import bst_pkg::*;
  initial btn = '0;
  // The driver sees the level as the block presents it
  function automatic logic [LEVEL_W-1:0] shown();
    return level;
  endfunction
  // Held 8 cycles so the synchroniser and its filter both see a settled level
  task automatic press(input int idx);
    @(posedge ref_clk) #1;
    btn[idx] = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    btn[idx] = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
endmodule // bst_panel_model

// File: tb/backlight_standby_timer_bench.sv
// Self-checking bench for the backlight standby timer
`timescale 1ns/10ps
module backlight_standby_timer_bench;
  import bst_pkg::*;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  logic                par_wr = 1'b0;
  logic                par_rd = 1'b0;
  logic [ADDR_W-1:0]   par_addr = '0;
  logic [DATA_W-1:0]   par_wdata = '0;
  logic [DATA_W-1:0]   par_rdata;
  logic                par_rd_valid;
  logic                par_err;
  logic [LEVEL_W-1:0]  backlight_level;
  logic                bl_standby;
  logic [BUTTONS-1:0]  btn;
  int                  n_mismatch = 0;
  int                  checks = 0;
  int                  cyc = 0;

  always #5 ref_clk = ~ref_clk;

  // Ten-cycle seconds keep a 60 s period near 600 cycles
  bst_backlight_timer #(.TICK_CYCLES(10)) bst_backlight_timer_i (
    .ref_clk(ref_clk), .rst(rst), .btn(btn), .par_wr(par_wr), .par_rd(par_rd),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rd_valid(par_rd_valid),
    .par_err(par_err), .backlight_level(backlight_level), .bl_standby(bl_standby));
  bst_panel_model bst_panel_model_i (.ref_clk(ref_clk), .level(backlight_level), .btn(btn));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One access; a read expected without error compares its data against d
  task automatic acc(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic err);
    @(posedge ref_clk) #1;
    // Pulses of the previous access must have dropped after one cycle
    chk("par_rd_valid idle", 16'h0000, 16'(par_rd_valid));
    chk("par_err idle", 16'h0000, 16'(par_err));
    par_wr = wr;
    par_rd = ~wr;
    par_addr = a;
    par_wdata = d;
    @(posedge ref_clk) #1;
    par_wr = 1'b0;
    par_rd = 1'b0;
    chk("par_err", 16'(err), 16'(par_err));
    chk("par_rd_valid", 16'(!wr), 16'(par_rd_valid));
    if (!wr && !err) begin
      chk("par_rdata", d, par_rdata);
    end
  endtask

  task automatic state(input logic [3:0] lv, input logic sb);
    chk("backlight_level", 16'(lv), 16'(backlight_level));
    chk("driver level", 16'(lv), 16'(bst_panel_model_i.shown()));
    chk("bl_standby", 16'(sb), 16'(bl_standby));
  endtask

  // Standby lands 591 to 600 cycles after a push; callers look at 581 and 601
  task automatic wait_sb();
    repeat (20) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    state(OP_BRIGHT_RST, 1'b0);
    acc(1'b0, OP_BRIGHT_ADDR, 16'h0006, 1'b0);
    acc(1'b0, SB_TIMEOUT_ADDR, 16'h0384, 1'b0);
    acc(1'b0, SB_BRIGHT_ADDR, 16'h0000, 1'b0);
    $display("test defaults done");
    acc(1'b1, OP_BRIGHT_ADDR, 16'h0009, 1'b0);
    acc(1'b1, OP_BRIGHT_ADDR, 16'h000a, 1'b1);
    acc(1'b1, 12'h025, 16'h0001, 1'b1);
    acc(1'b0, OP_BRIGHT_ADDR, 16'h0009, 1'b0);
    acc(1'b0, 12'h000, 16'h0000, 1'b1);
    state(4'h9, 1'b0);
    acc(1'b1, SB_BRIGHT_ADDR, 16'h000a, 1'b1);
    acc(1'b1, SB_BRIGHT_ADDR, 16'h0001, 1'b0);
    acc(1'b1, SB_TIMEOUT_ADDR, 16'h003b, 1'b1);
    acc(1'b1, SB_TIMEOUT_ADDR, 16'h2710, 1'b1);
    acc(1'b1, SB_TIMEOUT_ADDR, 16'h270f, 1'b0);
    acc(1'b0, SB_TIMEOUT_ADDR, 16'h270f, 1'b0);
    acc(1'b1, SB_TIMEOUT_ADDR, 16'h003c, 1'b0);
    $display("test limits done");
    bst_panel_model_i.press(0);
    repeat (570) @(posedge ref_clk);
    #1;
    state(4'h9, 1'b0);
    wait_sb();
    state(4'h1, 1'b1);
    $display("test standby done");
    // Second push mid-period must push standby out past the first deadline
    for (int i = 0; i < BUTTONS; i++) begin
      bst_panel_model_i.press(i);
      state(4'h9, 1'b0);
      repeat (300) @(posedge ref_clk);
      bst_panel_model_i.press(i);
      repeat (570) @(posedge ref_clk);
      #1;
      state(4'h9, 1'b0);
      wait_sb();
      state(4'h1, 1'b1);
    end
    $display("test buttons done");
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    state(OP_BRIGHT_RST, 1'b0);
    acc(1'b0, SB_TIMEOUT_ADDR, 16'h0384, 1'b0);
    acc(1'b0, SB_BRIGHT_ADDR, 16'h0000, 1'b0);
    $display("test restart done");
    tally_and_finish();
  end
endmodule // backlight_standby_timer_bench
